// ===== common/tbp_params.svh
// Constants of the token-bus parameter controller.
// Included by the package and the controller design file; definitions only.
`ifndef TBP_PARAMS_SVH
`define TBP_PARAMS_SVH
// Register offsets
`define TBP_A_CYCLE 4'h0
`define TBP_A_MAXNODE 4'h1
`define TBP_A_POLLCNT 4'h2
`define TBP_A_FRAMES 4'h3
`define TBP_A_STATUS 4'h4
`define TBP_A_IRQSTAT 4'h5
`define TBP_A_IRQMASK 4'h6
// Reset and default values
`define TBP_RST_CYCLE 8'h00
`define TBP_RST_MAXNODE 8'h3E
`define TBP_RST_POLLCNT 8'h04
`define TBP_RST_FRAMES 8'h0A
// Allowed ranges
`define TBP_MIN_CYCLE 8'h05
`define TBP_MAX_CYCLE 8'hFF
`define TBP_MIN_MAXNODE 8'h02
`define TBP_MAX_MAXNODE 8'h3E
`define TBP_MIN_POLLCNT 8'h01
`define TBP_MAX_POLLCNT 8'h3E
`define TBP_MIN_FRAMES 8'h05
`define TBP_MAX_FRAMES 8'hFF
`define TBP_MIN_NODE 6'h01
`define TBP_MAX_NODE 6'h3E
// Interrupt bit positions
`define TBP_I_REFUSE 0
`define TBP_I_RANGE 1
`define TBP_I_CONFLICT 2
`define TBP_I_EVERR 3
`define TBP_I_NVERR 4
`define TBP_I_COMMERR 5
// Timing: clock period and cycle-time unit, both in ns
`define TBP_CLK_NS 100
`define TBP_UNIT_NS 100000
`endif

// ===== common/tbp_pkg.sv
// Types of the token-bus parameter controller.
// Assumes tbp_params.svh sits on the include path.
`include "tbp_params.svh"
package tbp_pkg;
  // Start-up phases
  typedef enum logic [1:0] {PH_SETTLE, PH_LOAD, PH_RUN} tbp_phase_t;
  // Network parameter set
  typedef struct packed {
    logic [7:0] cycle;
    logic [7:0] maxNode;
    logic [7:0] pollCnt;
    logic [7:0] frames;
  } tbp_prm_t;
  // Whole state of the controller
  typedef struct packed {
    tbp_phase_t phase;
    logic [2:0] roleS;
    logic [5:0] nodeS1;
    logic [5:0] nodeS2;
    logic [5:0] nodeS3;
    logic [1:0] settle;
    logic polledRole;
    logic [5:0] ownNode;
    tbp_prm_t prm;
    logic [7:0] irqStat;
    logic [7:0] irqMask;
    logic [7:0] rdData;
    logic conflict;
    logic ledIn;
    logic ledCe;
    logic ledHe;
    logic [9:0] unitCnt;
    logic [7:0] cycCnt;
    logic [7:0] evCount;
    logic evGrant;
    logic evReject;
    logic [5:0] pollNode;
    logic [5:0] pollLeft;
    logic pollStb;
    logic nvWr;
    logic [1:0] nvIdx;
    logic [7:0] nvData;
    logic distStb;
  } tbp_state_t;
endpackage : tbp_pkg

// ===== rtl/tbp_range_chk.sv
// Range check of one parameter value.
// Pure combinational; ZERO_OK admits zero as an extra legal value.
`timescale 1ns/1ps
`default_nettype none
module tbp_range_chk #(
  parameter logic [7:0] MIN_V = 8'h00,
  parameter logic [7:0] MAX_V = 8'hFF,
  parameter bit ZERO_OK = 1'b0
) (
  // Value under test
  input wire logic [7:0] value,
  // Legal flag
  output logic ok
);
  // Inside the window, or zero where zero means automatic
  always_comb begin
    ok = ((value >= MIN_V) && (value <= MAX_V)) || (ZERO_OK && (value == 8'h00));
  end
endmodule : tbp_range_chk
`default_nettype wire

// ===== rtl/tbp_param_ctrl.sv
// Polling role and network parameter controller of a token-bus node.
// Assumes link logic, NV memory and event source run on sys_clk.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tbp_params.svh"
module tbp_param_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Switches (pins)
  input wire logic roleSwitch,
  input wire logic [5:0] nodeSwitch,
  // Link status
  input wire logic dataLinkOn,
  input wire logic netJoined,
  input wire logic tokenBack,
  input wire logic pollReady,
  // Parameter distribution
  input wire logic distValid,
  input wire tbp_pkg::tbp_prm_t distIn,
  output logic distStb,
  output tbp_pkg::tbp_prm_t distOut,
  // Polling
  output logic pollStb,
  output logic [5:0] pollNode,
  // Event transmissions
  input wire logic evReq,
  output logic evGrant,
  output logic evReject,
  // Non-volatile copy
  input wire tbp_pkg::tbp_prm_t nvCopy,
  input wire logic nvCopyOk,
  output logic nvWr,
  output logic [1:0] nvIdx,
  output logic [7:0] nvData,
  // Indicators and flags
  output logic inNetworkInd,
  output logic commErrorInd,
  output logic hostErrorInd,
  output logic conflictFlag,
  output logic cycleTick,
  output logic irq
);
  import tbp_pkg::*;

  localparam int UNIT_CYC = `TBP_UNIT_NS / `TBP_CLK_NS;
  localparam logic [9:0] UNIT_LAST = 10'(UNIT_CYC - 1);

  tbp_state_t st_r;      // Registered state
  tbp_state_t st_nxt;    // Next state
  logic [3:0] rangeOk;   // Per-parameter legality of write data
  logic isPrm;           // Write targets a parameter
  logic wrAccept;        // Parameter write taken
  logic wrDiffer;        // Taken write changes the value
  logic cycStart;        // Start of a communications cycle
  logic [7:0] evAllowed; // Event sends per token cycle
  logic [9:0] evTmp;     // Budget plus rounding
  logic [7:0] curVal;    // Present value at write index
  logic [7:0] setIrq;    // Events this cycle
  logic [5:0] nextNode;  // Next node to poll

  // Range checkers, one per parameter
  tbp_range_chk #(.MIN_V(`TBP_MIN_CYCLE), .MAX_V(`TBP_MAX_CYCLE), .ZERO_OK(1'b1)) uChkCyc (
    .value(regWrData), .ok(rangeOk[0]));
  tbp_range_chk #(.MIN_V(`TBP_MIN_MAXNODE), .MAX_V(`TBP_MAX_MAXNODE), .ZERO_OK(1'b0)) uChkMax (
    .value(regWrData), .ok(rangeOk[1]));
  tbp_range_chk #(.MIN_V(`TBP_MIN_POLLCNT), .MAX_V(`TBP_MAX_POLLCNT), .ZERO_OK(1'b0)) uChkPol (
    .value(regWrData), .ok(rangeOk[2]));
  tbp_range_chk #(.MIN_V(`TBP_MIN_FRAMES), .MAX_V(`TBP_MAX_FRAMES), .ZERO_OK(1'b0)) uChkFrm (
    .value(regWrData), .ok(rangeOk[3]));

  // Decode of parameter writes
  always_comb begin
    isPrm = (regAddr <= `TBP_A_FRAMES);
    case (regAddr[1:0])
      2'd0: curVal = st_r.prm.cycle;
      2'd1: curVal = st_r.prm.maxNode;
      2'd2: curVal = st_r.prm.pollCnt;
      default: curVal = st_r.prm.frames;
    endcase
    wrAccept = regWr && isPrm && (st_r.phase == PH_RUN) && !dataLinkOn
               && rangeOk[regAddr[1:0]];
    wrDiffer = wrAccept && (curVal != regWrData);
  end

  // Event budget: ten frames give four sends, three frames per extra one
  always_comb begin
    evTmp = {2'b00, st_r.prm.frames} + 10'd2;
    evAllowed = 8'(evTmp / 10'd3);
  end

  // Cycle start: fixed timer when set and link on, else token return
  always_comb begin
    if (dataLinkOn && (st_r.prm.cycle != 8'h00)) begin
      cycStart = (st_r.unitCnt == UNIT_LAST) && (st_r.cycCnt == 8'h00);
    end else begin
      cycStart = tokenBack;
    end
  end

  // Next node, wrapping at the maximum node number
  always_comb begin
    if ({2'b00, st_r.pollNode} >= st_r.prm.maxNode) begin
      nextNode = `TBP_MIN_NODE;
    end else begin
      nextNode = st_r.pollNode + 6'd1;
    end
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    setIrq = 8'h00;
    st_nxt.nvWr = 1'b0;
    st_nxt.distStb = 1'b0;
    st_nxt.pollStb = 1'b0;
    st_nxt.evGrant = 1'b0;
    st_nxt.evReject = 1'b0;
    st_nxt.rdData = 8'h00;
    // Pin synchronisers
    st_nxt.roleS = {st_r.roleS[1:0], roleSwitch};
    st_nxt.nodeS1 = nodeSwitch;
    st_nxt.nodeS2 = st_r.nodeS1;
    st_nxt.nodeS3 = st_r.nodeS2;
    case (st_r.phase)
      // Wait until switch samples agree
      PH_SETTLE: begin
        if ((st_r.roleS[1] == st_r.roleS[2]) && (st_r.nodeS2 == st_r.nodeS3)) begin
          st_nxt.settle = st_r.settle + 2'd1;
          if (st_r.settle == 2'd3) begin
            st_nxt.phase = PH_LOAD;
          end
        end else begin
          st_nxt.settle = 2'd0;
        end
      end
      // Latch role and node, restore parameters
      PH_LOAD: begin
        st_nxt.polledRole = st_r.roleS[2];
        st_nxt.ownNode = st_r.nodeS3;
        if ((st_r.nodeS3 < `TBP_MIN_NODE) || (st_r.nodeS3 > `TBP_MAX_NODE)) begin
          st_nxt.ledCe = 1'b1;
          setIrq[`TBP_I_COMMERR] = 1'b1;
        end
        if (nvCopyOk) begin
          st_nxt.prm = nvCopy;
        end else begin
          st_nxt.ledHe = 1'b1;
          setIrq[`TBP_I_NVERR] = 1'b1;
        end
        st_nxt.pollNode = st_r.nodeS3;
        st_nxt.phase = PH_RUN;
      end
      // Normal operation
      PH_RUN: begin
        st_nxt.ledIn = netJoined && !st_r.ledCe && !st_r.ledHe;
        // Fixed cycle timer, idle while link off
        if (dataLinkOn && (st_r.prm.cycle != 8'h00)) begin
          st_nxt.unitCnt = (st_r.unitCnt == UNIT_LAST) ? 10'd0 : st_r.unitCnt + 10'd1;
          if (st_r.unitCnt == UNIT_LAST) begin
            st_nxt.cycCnt = (st_r.cycCnt == 8'h00) ? st_r.prm.cycle - 8'h01
                                                   : st_r.cycCnt - 8'h01;
          end
        end else begin
          st_nxt.unitCnt = 10'd0;
          st_nxt.cycCnt = 8'h00;
        end
        // Polling node work at cycle start
        if (cycStart && !st_r.polledRole && st_r.ledIn) begin
          st_nxt.pollLeft = st_r.prm.pollCnt[5:0];
          st_nxt.distStb = 1'b1;
        end else if ((st_r.pollLeft != 6'd0) && pollReady) begin
          st_nxt.pollLeft = st_r.pollLeft - 6'd1;
          st_nxt.pollNode = nextNode;
          st_nxt.pollStb = 1'b1;
        end
        // Event budget per token cycle
        if (cycStart) begin
          st_nxt.evCount = 8'h00;
        end
        if (evReq) begin
          if (dataLinkOn && (st_r.evCount >= evAllowed) && !cycStart) begin
            st_nxt.evReject = 1'b1;
            setIrq[`TBP_I_EVERR] = 1'b1;
          end else begin
            st_nxt.evGrant = 1'b1;
            if (dataLinkOn) begin
              st_nxt.evCount = (cycStart ? 8'h00 : st_r.evCount) + 8'h01;
            end
          end
        end
        // Distributed parameters from the polling node
        if (st_r.polledRole && distValid && !wrAccept) begin
          st_nxt.prm = distIn;
        end
        // Parameter writes
        if (regWr && isPrm && !wrAccept) begin
          if (dataLinkOn) begin
            setIrq[`TBP_I_REFUSE] = 1'b1;
          end else begin
            setIrq[`TBP_I_RANGE] = 1'b1;
          end
        end
        if (wrAccept) begin
          case (regAddr[1:0])
            2'd0: st_nxt.prm.cycle = regWrData;
            2'd1: st_nxt.prm.maxNode = regWrData;
            2'd2: st_nxt.prm.pollCnt = regWrData;
            default: st_nxt.prm.frames = regWrData;
          endcase
          st_nxt.nvWr = 1'b1;
          st_nxt.nvIdx = regAddr[1:0];
          st_nxt.nvData = regWrData;
        end
        if (wrDiffer) begin
          st_nxt.conflict = 1'b1;
          setIrq[`TBP_I_CONFLICT] = 1'b1;
        end
      end
      default: begin
        st_nxt.phase = PH_SETTLE;
      end
    endcase
    // Mask write
    if (regWr && (regAddr == `TBP_A_IRQMASK)) begin
      st_nxt.irqMask = regWrData;
    end
    // Status: write one to clear; a new event wins
    if (regWr && (regAddr == `TBP_A_IRQSTAT)) begin
      st_nxt.irqStat = (st_r.irqStat & ~regWrData) | setIrq;
      st_nxt.conflict = (st_r.conflict && !regWrData[`TBP_I_CONFLICT]) || wrDiffer;
    end else begin
      st_nxt.irqStat = st_r.irqStat | setIrq;
    end
    // Read data, valid in the next cycle only
    if (regRd) begin
      case (regAddr)
        `TBP_A_CYCLE: st_nxt.rdData = st_r.prm.cycle;
        `TBP_A_MAXNODE: st_nxt.rdData = st_r.prm.maxNode;
        `TBP_A_POLLCNT: st_nxt.rdData = st_r.prm.pollCnt;
        `TBP_A_FRAMES: st_nxt.rdData = st_r.prm.frames;
        `TBP_A_STATUS: st_nxt.rdData = {2'b00, dataLinkOn, st_r.conflict, st_r.ledHe,
                                        st_r.ledCe, st_r.ledIn, st_r.polledRole};
        `TBP_A_IRQSTAT: st_nxt.rdData = st_r.irqStat;
        `TBP_A_IRQMASK: st_nxt.rdData = st_r.irqMask;
        default: st_nxt.rdData = 8'h00;
      endcase
    end
  end

  // State register with synchronous reset to defaults
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.phase <= PH_SETTLE;
      st_r.prm.cycle <= `TBP_RST_CYCLE;
      st_r.prm.maxNode <= `TBP_RST_MAXNODE;
      st_r.prm.pollCnt <= `TBP_RST_POLLCNT;
      st_r.prm.frames <= `TBP_RST_FRAMES;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state; cycleTick also follows dataLinkOn and tokenBack
  always_comb begin
    regRdData = st_r.rdData;
    distStb = st_r.distStb;
    distOut = st_r.prm;
    pollStb = st_r.pollStb;
    pollNode = st_r.pollNode;
    evGrant = st_r.evGrant;
    evReject = st_r.evReject;
    nvWr = st_r.nvWr;
    nvIdx = st_r.nvIdx;
    nvData = st_r.nvData;
    inNetworkInd = st_r.ledIn;
    commErrorInd = st_r.ledCe;
    hostErrorInd = st_r.ledHe;
    conflictFlag = st_r.conflict;
    cycleTick = cycStart && (st_r.phase == PH_RUN);
    irq = |(st_r.irqStat & st_r.irqMask);
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_ROLE_FIXED: assert property (
    (st_r.phase == PH_RUN) |=> $stable(st_r.polledRole)) else $error("role changed");
  AST_LED_OK: assert property (
    inNetworkInd |-> (!commErrorInd && !hostErrorInd)) else $error("error lamp lit");
  AST_NV_SAVE: assert property (
    wrAccept |=> (nvWr && (nvData == $past(regWrData)))) else $error("no NV save");
  AST_CYC_RANGE: assert property (
    (st_r.prm.cycle == 8'h00) || (st_r.prm.cycle >= 8'h05)) else $error("bad cycle time");
  AST_TIMER_IDLE: assert property (
    !dataLinkOn |=> ((st_r.unitCnt == 10'd0) && (st_r.cycCnt == 8'h00))) else $error("timer ran");
  AST_POLL_MAX: assert property (
    pollStb |-> ((pollNode != 6'd0) && ({2'b00, pollNode} <= st_r.prm.maxNode)))
    else $error("polled above max");
  AST_POLL_CNT: assert property (
    distStb |-> (st_r.pollLeft == st_r.prm.pollCnt[5:0])) else $error("poll count wrong");
  AST_EV_DEFAULT: assert property (
    (st_r.prm.frames == 8'h0A) |-> (evAllowed == 8'h04)) else $error("budget not four");
  AST_EV_LIMIT: assert property (
    (evReq && dataLinkOn && !cycStart && (st_r.phase == PH_RUN) && (st_r.evCount >= evAllowed))
    |=> (evReject && !evGrant)) else $error("over-budget send granted");
  AST_REFUSE: assert property (
    (regWr && isPrm && dataLinkOn && !distValid) |=> $stable(st_r.prm))
    else $error("write taken with link on");
  AST_CONFLICT: assert property (
    wrDiffer |=> (conflictFlag && st_r.irqStat[`TBP_I_CONFLICT])) else $error("no conflict");
  AST_RANGE_KEEP: assert property (
    (regWr && isPrm && !rangeOk[regAddr[1:0]] && !distValid) |=> $stable(st_r.prm))
    else $error("illegal value stored");
  AST_NODE_ERR: assert property (
    ((st_r.phase == PH_LOAD) &&
     ((st_r.nodeS3 < `TBP_MIN_NODE) || (st_r.nodeS3 > `TBP_MAX_NODE))) |=> commErrorInd)
    else $error("bad node not flagged");
  AST_NV_ERR: assert property (
    ((st_r.phase == PH_LOAD) && !nvCopyOk) |=> ##[0:2] hostErrorInd) else $error("no NV error");

  COV_WRITE: cover property (wrAccept ##1 nvWr);
  COV_REJECT: cover property (evReject);
  COV_POLL: cover property (distStb ##[1:20] pollStb);
endmodule : tbp_param_ctrl
`default_nettype wire

// ===== verification/tbp_net_model.sv
// Far side of the controller: ring peers and the non-volatile store.
// Assumes one clock shared with the controller; kick asks for a token return.
`timescale 1ns/1ps
`default_nettype none
module tbp_net_model (
  // Clock
  input wire logic sys_clk,
  // Bench control
  input wire logic kick,
  input wire logic corrupt,
  // Ring side
  output logic tokenBack,
  output logic pollReady,
  output logic netJoined,
  // Non-volatile store
  input wire logic nvWr,
  input wire logic [1:0] nvIdx,
  input wire logic [7:0] nvData,
  output tbp_pkg::tbp_prm_t nvCopy,
  output logic nvCopyOk
);
  import tbp_pkg::*;

  // Power-on content: a blank store holds the defaults
  initial begin
    tokenBack = 1'b0;
    pollReady = 1'b0;
    netJoined = 1'b1;
    nvCopyOk = 1'b1;
    nvCopy = {8'h00, 8'h3E, 8'h04, 8'h0A};
  end

  // Token returns on request; the ring is ready only every other cycle
  always @(posedge sys_clk) begin
    tokenBack <= kick;
    pollReady <= ~pollReady;
    // A save torn by a reset leaves the stored copy unusable
    nvCopyOk <= !corrupt;
    // Store each saved parameter, index 0 is the top byte
    if (nvWr) begin
      nvCopy[8*(3-nvIdx) +: 8] <= nvData;
    end
  end
endmodule : tbp_net_model
`default_nettype wire

// ===== verification/tb_token_bus_poll_param_control.sv
// Self-checking bench of the parameter controller with its ring model.
// Assumes tbp_params.svh on the include path and a 10 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin errTotal++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_token_bus_poll_param_control;
  import tbp_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData, nvData, rdv;
  logic roleSwitch = 1'b0, dataLinkOn = 1'b0, evReq = 1'b0, kick = 1'b0;
  logic [5:0] nodeSwitch = 6'h05, pollNode;
  logic tokenBack, pollReady, netJoined, distStb, pollStb, evGrant, evReject;
  logic nvCopyOk, nvWr, inNetworkInd, commErrorInd, hostErrorInd;
  logic conflictFlag, cycleTick, irq;
  logic [1:0] nvIdx;
  tbp_prm_t distOut, nvCopy;
  // Parameters offered by a polling peer, and a torn NV copy
  tbp_prm_t distIn = '0;
  logic distValid = 1'b0, corrupt = 1'b0;
  int errTotal = 0, nChecks = 0;

  // 100 ns clock
  always #50 sys_clk = ~sys_clk;

  tbp_param_ctrl tbp_param_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .roleSwitch(roleSwitch), .nodeSwitch(nodeSwitch),
    .dataLinkOn(dataLinkOn), .netJoined(netJoined), .tokenBack(tokenBack),
    .pollReady(pollReady), .distValid(distValid), .distIn(distIn),
    .distStb(distStb), .distOut(distOut), .pollStb(pollStb), .pollNode(pollNode),
    .evReq(evReq), .evGrant(evGrant), .evReject(evReject), .nvCopy(nvCopy),
    .nvCopyOk(nvCopyOk), .nvWr(nvWr), .nvIdx(nvIdx), .nvData(nvData),
    .inNetworkInd(inNetworkInd), .commErrorInd(commErrorInd),
    .hostErrorInd(hostErrorInd), .conflictFlag(conflictFlag),
    .cycleTick(cycleTick), .irq(irq));

  tbp_net_model tbp_net_model_inst (.sys_clk(sys_clk), .kick(kick), .corrupt(corrupt),
    .tokenBack(tokenBack), .pollReady(pollReady), .netJoined(netJoined),
    .nvWr(nvWr), .nvIdx(nvIdx), .nvData(nvData), .nvCopy(nvCopy),
    .nvCopyOk(nvCopyOk));

  // Verdict and end of run
  task automatic summarize();
    $display("checks=%0d errors=%0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // One-cycle register write; leaves time in the answer cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  // One-cycle register read; data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  // Read and compare one register
  task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
    rd(a, rdv);
    `CHK(rdv, e)
  endtask : rdChk

  // Reset with given switch settings, then wait past start-up
  task automatic doReset(input logic role, input logic [5:0] node);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    roleSwitch <= role;
    nodeSwitch <= node;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (16) @(posedge sys_clk);
  endtask : doReset

  // Ask the ring for a token return, let it land
  task automatic kickToken();
    @(posedge sys_clk);
    kick <= 1'b1;
    @(posedge sys_clk);
    kick <= 1'b0;
  endtask : kickToken

  // Count cycle starts over n cycles, and the clocks from first to last
  task automatic countTicks(input int n, output int c, output int gap);
    int first;
    c = 0;
    first = 0;
    gap = 0;
    for (int i = 1; i <= n; i++) begin
      @(posedge sys_clk);
      #1 if (cycleTick === 1'b1) begin
        c++;
        if (c == 1) first = i;
        gap = i - first;
      end
    end
  endtask : countTicks

  // Defaults, status and indicators after joining as polling node 5
  task automatic tDefaults();
    rdChk(4'h0, 8'h00);
    rdChk(4'h1, 8'h3E);
    rdChk(4'h2, 8'h04);
    rdChk(4'h3, 8'h0A);
    rdChk(4'h7, 8'h00);
    rdChk(4'h4, 8'h02);
    `CHK({inNetworkInd, commErrorInd, hostErrorInd}, 3'b100)
  endtask : tDefaults

  // Accepted, out-of-range and boundary writes; interrupt mask and clear
  task automatic tWrite();
    wr(4'h1, 8'h20);
    `CHK({nvWr, nvIdx, nvData}, {1'b1, 2'h1, 8'h20})
    `CHK(conflictFlag, 1'b1)
    wr(4'h1, 8'h3F);
    `CHK(nvWr, 1'b0)
    wr(4'h1, 8'h01);
    rdChk(4'h1, 8'h20);
    `CHK(irq, 1'b0)
    wr(4'h6, 8'h02);
    `CHK(irq, 1'b1)
    rdChk(4'h5, 8'h06);
    wr(4'h5, 8'h06);
    rdChk(4'h5, 8'h00);
    `CHK({irq, conflictFlag}, 2'b00)
    wr(4'h1, 8'h08);
    wr(4'h2, 8'h06);
    rdChk(4'h2, 8'h06);
  endtask : tWrite

  // Write while the link runs is refused and reported
  task automatic tRefuse();
    wr(4'h5, 8'hFF);
    @(posedge sys_clk) dataLinkOn <= 1'b1;
    wr(4'h2, 8'h07);
    `CHK(nvWr, 1'b0)
    rdChk(4'h2, 8'h06);
    rdChk(4'h5, 8'h01);
    @(posedge sys_clk) dataLinkOn <= 1'b0;
  endtask : tRefuse

  // Event budget per token cycle for a frame budget and its send limit
  task automatic tEvents(input logic [7:0] f, input int lim);
    wr(4'h3, f);
    wr(4'h5, 8'hFF);
    @(posedge sys_clk) dataLinkOn <= 1'b1;
    kickToken();
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      evReq <= 1'b1;
      @(posedge sys_clk);
      evReq <= 1'b0;
      #1 `CHK({evGrant, evReject}, (i < lim) ? 2'b10 : 2'b01)
    end
    rdChk(4'h5, 8'h08);
    @(posedge sys_clk) dataLinkOn <= 1'b0;
    @(posedge sys_clk);
    evReq <= 1'b1;
    @(posedge sys_clk);
    evReq <= 1'b0;
    #1 `CHK(evGrant, 1'b1)
  endtask : tEvents

  // Distribution and polling with wrap past the highest node
  task automatic tPoll();
    int k, seen;
    logic [5:0] n;
    k = 0;
    seen = 0;
    kickToken();
    repeat (30) begin
      @(posedge sys_clk);
      #1;
      if (distStb === 1'b1) begin
        seen++;
        `CHK(distOut, {8'h00, 8'h08, 8'h06, 8'h0A})
      end
      if (pollStb === 1'b1) begin
        n = 6'(5 + k + 1);
        if (n > 6'd8) n = n - 6'd8;
        `CHK(pollNode, n)
        k++;
      end
    end
    `CHK(k, 6)
    `CHK(seen, 1)
  endtask : tPoll

  // Fixed cycle timer idle with link off, 1000 clocks per unit with link on
  task automatic tTimer();
    int c, g;
    wr(4'h0, 8'h05);
    countTicks(6000, c, g);
    `CHK(c, 0)
    @(posedge sys_clk) dataLinkOn <= 1'b1;
    countTicks(10000, c, g);
    `CHK(c, 2)
    `CHK(g, 5000)
    @(posedge sys_clk) dataLinkOn <= 1'b0;
  endtask : tTimer

  // Bad node, torn NV copy, role swap across two reinits, adopted parameters
  task automatic tReinit();
    doReset(1'b1, 6'h00);
    rdChk(4'h4, 8'h05);
    `CHK({inNetworkInd, commErrorInd}, 2'b01)
    rdChk(4'h5, 8'h20);
    rdChk(4'h1, 8'h08);
    @(posedge sys_clk) corrupt <= 1'b1;
    doReset(1'b0, 6'h07);
    `CHK({inNetworkInd, hostErrorInd}, 2'b01)
    rdChk(4'h5, 8'h10);
    rdChk(4'h1, 8'h3E);
    @(posedge sys_clk) corrupt <= 1'b0;
    doReset(1'b0, 6'h07);
    `CHK({inNetworkInd, commErrorInd, hostErrorInd}, 3'b100)
    rdChk(4'h4, 8'h02);
    doReset(1'b1, 6'h07);
    `CHK({inNetworkInd, commErrorInd, hostErrorInd}, 3'b100)
    @(posedge sys_clk);
    distIn <= {8'h00, 8'h10, 8'h03, 8'h0C};
    distValid <= 1'b1;
    @(posedge sys_clk);
    distValid <= 1'b0;
    rdChk(4'h1, 8'h10);
    kickToken();
    repeat (20) begin
      @(posedge sys_clk);
      #1 `CHK({pollStb, distStb}, 2'b00)
    end
  endtask : tReinit

  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (16) @(posedge sys_clk);
    tDefaults();
    tWrite();
    tRefuse();
    tPoll();
    tEvents(8'h05, 2);
    tEvents(8'h0A, 4);
    tTimer();
    tReinit();
    summarize();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge sys_clk);
    errTotal++;
    summarize();
  end
endmodule : tb_token_bus_poll_param_control
`default_nettype wire
